// [rtl/bcs_clock_ctl.sv]
`timescale 1ns/1ps
module bcs_clock_ctl (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_crystal_tick,
  input wire logic i_vlp_tick,
  input wire logic i_fault_detect,
  input wire logic i_sleep3,
  input wire logic i_aux_src_vlp,
  input wire logic i_main_from_aux,
  input wire logic i_wdog_from_aux,
  input wire logic i_ctl_we,
  input wire logic [bcs_pkg::RANGE_W-1:0] i_range_wdata,
  input wire logic [bcs_pkg::DIV_W-1:0] i_div_wdata,
  input wire logic i_tune_we,
  input wire logic [bcs_pkg::TAP_W-1:0] i_tap_wdata,
  input wire logic [bcs_pkg::MOD_W-1:0] i_mod_wdata,
  input wire logic i_fault_clr,
  input wire logic i_pin6_sel_we,
  input wire logic i_pin6_sel_wdata,
  input wire logic i_pin7_sel_we,
  input wire logic i_pin7_sel_wdata,
  output logic [bcs_pkg::RANGE_W-1:0] o_oscillator_range_select,
  output logic [bcs_pkg::DIV_W-1:0] o_aux_clock_divider,
  output logic [bcs_pkg::DIV_W-1:0] o_aux_div_applied,
  output logic [bcs_pkg::TAP_W-1:0] o_oscillator_tap_select,
  output logic [bcs_pkg::MOD_W-1:0] o_oscillator_modulation,
  output logic o_oscillator_fault_flag,
  output logic o_main_on_aux,
  output logic o_wdog_on_aux,
  output logic o_aux_en,
  output logic o_port_two_bit_six_function_select,
  output logic o_port_two_bit_seven_function_select,
  output logic o_pin7_gpio_en,
  output logic o_pin7_schmitt_en
);
  logic xt_s1_q, xt_s2_q, xt_s3_q;
  logic vl_s1_q, vl_s2_q, vl_s3_q;
  logic fd_s1_q, fd_s2_q;
  logic [bcs_pkg::RANGE_W-1:0] range_q, range_d;
  logic [bcs_pkg::DIV_W-1:0] div_q, div_d;
  logic [bcs_pkg::TAP_W-1:0] tap_q, tap_d;
  logic [bcs_pkg::MOD_W-1:0] mod_q, mod_d;
  logic fault_q, fault_d;
  logic main_aux_q, main_aux_d;
  logic wdog_aux_q, wdog_aux_d;
  logic sel6_q, sel6_d, sel7_q, sel7_d;
  logic gpio7_q, gpio7_d, trig7_q, trig7_d;
  logic div_tick, crystal_fault, crystal_in_use;

  bcs_div_if dbus ();

  bcs_aux_div u_div (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_sleep3(i_sleep3),
    .bus(dbus)
  );

  // pin-domain inputs are synchronised before any edge detection
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      xt_s1_q <= 1'b0;
      xt_s2_q <= 1'b0;
      xt_s3_q <= 1'b0;
      vl_s1_q <= 1'b0;
      vl_s2_q <= 1'b0;
      vl_s3_q <= 1'b0;
      fd_s1_q <= 1'b0;
      fd_s2_q <= 1'b0;
    end else begin
      xt_s1_q <= i_crystal_tick;
      xt_s2_q <= xt_s1_q;
      xt_s3_q <= xt_s2_q;
      vl_s1_q <= i_vlp_tick;
      vl_s2_q <= vl_s1_q;
      vl_s3_q <= vl_s2_q;
      fd_s1_q <= i_fault_detect;
      fd_s2_q <= fd_s1_q;
    end
  end

  assign div_tick = i_aux_src_vlp ? (vl_s2_q & ~vl_s3_q) : (xt_s2_q & ~xt_s3_q);
  assign dbus.req_div = div_q;
  assign dbus.aux_tick = div_tick;
  // detector only counts while the crystal feeds the aux clock
  assign crystal_in_use = !i_aux_src_vlp;
  assign crystal_fault = fd_s2_q && crystal_in_use;

  always_comb begin
    range_d = range_q;
    div_d = div_q;
    tap_d = tap_q;
    mod_d = mod_q;
    sel6_d = sel6_q;
    sel7_d = sel7_q;
    fault_d = fault_q;
    // (RL2) divider readback holds written value
    if (i_ctl_we) begin
      range_d = i_range_wdata;
      div_d = i_div_wdata;
    end
    if (i_tune_we) begin
      tap_d = i_tap_wdata;
      mod_d = i_mod_wdata;
    end
    if (i_pin6_sel_we) begin
      sel6_d = i_pin6_sel_wdata;
    end
    if (i_pin7_sel_we) begin
      sel7_d = i_pin7_sel_wdata;
    end
    // (RL16) sticky fault, set beats clear
    if (i_fault_clr) begin
      fault_d = 1'b0;
    end
    if (crystal_fault) begin
      fault_d = 1'b1;
    end
    // (RL15) pin seven function select
    gpio7_d = !sel7_d;
    trig7_d = sel7_d;
    // (RL4) (RL14) main clock failsafe
    main_aux_d = i_main_from_aux && !(crystal_in_use && fault_d);
    // (RL5) watchdog clock failsafe
    wdog_aux_d = i_wdog_from_aux && !(crystal_in_use && fault_d);
  end

  always_ff @(posedge i_ref_clk) begin
    // (RL10) range resets to its default
    if (!i_rstn) begin
      range_q <= bcs_pkg::RANGE_RESET;
      div_q <= bcs_pkg::DIV_RESET;
      tap_q <= bcs_pkg::TAP_RESET;
      mod_q <= bcs_pkg::MOD_RESET;
      fault_q <= 1'b0;
      main_aux_q <= 1'b0;
      wdog_aux_q <= 1'b0;
      sel6_q <= 1'b0;
      sel7_q <= 1'b0;
      gpio7_q <= 1'b1;
      trig7_q <= 1'b0;
    end else begin
      range_q <= range_d;
      div_q <= div_d;
      tap_q <= tap_d;
      mod_q <= mod_d;
      fault_q <= fault_d;
      main_aux_q <= main_aux_d;
      wdog_aux_q <= wdog_aux_d;
      sel6_q <= sel6_d;
      sel7_q <= sel7_d;
      gpio7_q <= gpio7_d;
      trig7_q <= trig7_d;
    end
  end

  logic [bcs_pkg::DIV_W-1:0] applied_q;
  logic aux_en_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      applied_q <= bcs_pkg::DIV_RESET;
      aux_en_q <= 1'b0;
    end else begin
      applied_q <= dbus.applied_div;
      aux_en_q <= dbus.aux_en;
    end
  end

  assign o_oscillator_range_select = range_q;
  assign o_aux_clock_divider = div_q;
  assign o_aux_div_applied = applied_q;
  assign o_oscillator_tap_select = tap_q;
  assign o_oscillator_modulation = mod_q;
  assign o_oscillator_fault_flag = fault_q;
  assign o_main_on_aux = main_aux_q;
  assign o_wdog_on_aux = wdog_aux_q;
  assign o_aux_en = aux_en_q;
  assign o_port_two_bit_six_function_select = sel6_q;
  assign o_port_two_bit_seven_function_select = sel7_q;
  assign o_pin7_gpio_en = gpio7_q;
  assign o_pin7_schmitt_en = trig7_q;

  AST_RANGE_RESET: assert property (@(posedge i_ref_clk) // RL10
    $rose(i_rstn) |-> o_oscillator_range_select == bcs_pkg::RANGE_RESET)
    else $error("range not default after reset");
  AST_DIV_READBACK: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL2
    i_ctl_we |=> o_aux_clock_divider == $past(i_div_wdata))
    else $error("divider readback wrong");
  AST_FAULT_SET: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL16
    (i_fault_detect && !i_aux_src_vlp) [*3] |=> o_oscillator_fault_flag)
    else $error("fault flag not set");
  AST_FAULT_STICKY: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL16
    (o_oscillator_fault_flag && !i_fault_clr) |=> o_oscillator_fault_flag)
    else $error("fault flag dropped");
  AST_MAIN_FAILSAFE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL4
    (fault_q && !i_fault_clr && !i_aux_src_vlp) |=> !o_main_on_aux)
    else $error("main clock stayed on crystal");
  AST_MAIN_BLOCK: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL14
    (o_main_on_aux && !i_aux_src_vlp) |-> !$past(fault_d))
    else $error("crystal used as main during fault");
  AST_WDOG_FAILSAFE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL5
    (fault_q && !i_fault_clr && !i_aux_src_vlp) |=> !o_wdog_on_aux)
    else $error("watchdog stayed on crystal");
  AST_PIN7_FUNC: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL15
    o_pin7_schmitt_en == o_port_two_bit_seven_function_select &&
    o_pin7_gpio_en != o_pin7_schmitt_en)
    else $error("pin seven function wrong");
  AST_FAULT_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL16
    (i_fault_clr && !fd_s2_q) |=> !o_oscillator_fault_flag)
    else $error("fault flag not cleared");
  AST_WDOG_BLOCK: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // RL5
    (o_oscillator_fault_flag && !$past(i_aux_src_vlp)) |-> !o_wdog_on_aux)
    else $error("watchdog on crystal during fault");

  COV_FAULT: cover property (@(posedge i_ref_clk) $rose(o_oscillator_fault_flag));
  COV_MAIN_SWITCH: cover property (@(posedge i_ref_clk) $fell(o_main_on_aux));
  COV_DIV_APPLY: cover property (@(posedge i_ref_clk) $changed(o_aux_div_applied));
  COV_WDOG_SWITCH: cover property (@(posedge i_ref_clk) $fell(o_wdog_on_aux));
  COV_FLAG_CLEAR: cover property (@(posedge i_ref_clk) $fell(o_oscillator_fault_flag));
endmodule

// [rtl/bcs_pkg.sv]
// How it works
// (RL1) software waits one aux period before state three
// (RL2) divider readback returns last written value
// (RL3) settling wait only before first state three
// (RL4) fault moves main clock to internal oscillator
// (RL5) fault moves watchdog clock to internal oscillator
// (RL6) lowering past 13 steps through 13 first
// (RL7) listed range changes may be direct
// (RL8) raising past 13 steps through 7 first; the testbench goes through 7 only when it starts below 12
// (RL9) at range 15 go to 7 before tuning
// (RL10) range select resets to 7
// (RL11) startup: clear tuning, load control, load tuning
// (RL12) single range steps avoid oscillator dead time
// (RL13) bypass mode needs both pin selects set
// (RL14) fault flag blocks crystal as main clock
// (RL15) pin seven select disables gpio, enables trigger
// (RL16) fault flag sticky until cleared without fault
package bcs_pkg;
  localparam int RANGE_W = 4;
  localparam int DIV_W = 2;
  localparam int TAP_W = 3;
  localparam int MOD_W = 5;
  localparam logic [RANGE_W-1:0] RANGE_RESET = 4'h7;
  localparam logic [DIV_W-1:0] DIV_RESET = 2'h0;
  localparam logic [TAP_W-1:0] TAP_RESET = 3'h3;
  localparam logic [MOD_W-1:0] MOD_RESET = 5'h00;
  localparam logic [3:0] DIV_ONE_HOT_BASE = 4'h1;
  // main clock source selections
  typedef enum logic [1:0] {
    BCS_MSRC_OSC,
    BCS_MSRC_AUX
  } bcs_msrc_t;
  typedef enum logic [1:0] {
    BCS_AUX_CRYSTAL,
    BCS_AUX_VLP
  } bcs_aux_t;
endpackage

// [rtl/bcs_div_if.sv]
`timescale 1ns/1ps
interface bcs_div_if;
  logic [bcs_pkg::DIV_W-1:0] req_div;
  logic aux_tick;
  logic [bcs_pkg::DIV_W-1:0] applied_div;
  logic aux_en;
  modport ctl (output req_div, output aux_tick, input applied_div, input aux_en);
  modport div (input req_div, input aux_tick, output applied_div, output aux_en);
endinterface

// [rtl/bcs_aux_div.sv]
`timescale 1ns/1ps
module bcs_aux_div (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_sleep3,
  bcs_div_if.div bus
);
  logic [bcs_pkg::DIV_W-1:0] applied_q, applied_d;
  logic [7:0] cnt_q, cnt_d;
  logic en_q, en_d;
  logic [7:0] lim;

  // the request is applied on an aux edge; while in sleep a pending change is held back until sleep ends
  always_comb begin
    applied_d = applied_q;
    cnt_d = cnt_q;
    en_d = 1'b0;
    lim = 8'((1 << applied_q) - 1);
    if (bus.aux_tick) begin
      if (i_sleep3 && bus.req_div != applied_q) begin
        applied_d = applied_q;
      end else begin
        applied_d = bus.req_div;
      end
      if (cnt_q >= lim) begin
        cnt_d = 8'h00;
        en_d = 1'b1;
      end else begin
        cnt_d = 8'(cnt_q + 8'h01);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      applied_q <= bcs_pkg::DIV_RESET;
      cnt_q <= 8'h00;
      en_q <= 1'b0;
    end else begin
      applied_q <= applied_d;
      cnt_q <= cnt_d;
      en_q <= en_d;
    end
  end

  assign bus.applied_div = applied_q;
  assign bus.aux_en = en_q;
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module tb;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_crystal_tick = 1'b0, i_vlp_tick = 1'b0, i_fault_detect = 1'b0, i_sleep3 = 1'b0;
  logic i_aux_src_vlp = 1'b0, i_main_from_aux = 1'b0, i_wdog_from_aux = 1'b0;
  logic i_ctl_we = 1'b0, i_tune_we = 1'b0, i_fault_clr = 1'b0;
  logic [bcs_pkg::RANGE_W-1:0] i_range_wdata = '0, m_range;
  logic [bcs_pkg::DIV_W-1:0] i_div_wdata = '0, m_div, o_aux_clock_divider, o_aux_div_applied;
  logic [bcs_pkg::TAP_W-1:0] i_tap_wdata = '0, m_tap, o_oscillator_tap_select;
  logic [bcs_pkg::MOD_W-1:0] i_mod_wdata = '0, m_mod, o_oscillator_modulation;
  logic i_pin6_sel_we = 1'b0, i_pin6_sel_wdata = 1'b0;
  logic i_pin7_sel_we = 1'b0, i_pin7_sel_wdata = 1'b0;
  logic [bcs_pkg::RANGE_W-1:0] o_oscillator_range_select;
  logic o_oscillator_fault_flag, o_main_on_aux, o_wdog_on_aux, o_aux_en;
  logic o_port_two_bit_six_function_select, o_port_two_bit_seven_function_select;
  logic o_pin7_gpio_en, o_pin7_schmitt_en;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] lfsr = 32'h000129ab;
  bcs_clock_ctl i_bcs_clock_ctl (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_crystal_tick(i_crystal_tick), .i_vlp_tick(i_vlp_tick), .i_fault_detect(i_fault_detect),
    .i_sleep3(i_sleep3), .i_aux_src_vlp(i_aux_src_vlp), .i_main_from_aux(i_main_from_aux),
    .i_wdog_from_aux(i_wdog_from_aux), .i_ctl_we(i_ctl_we), .i_range_wdata(i_range_wdata),
    .i_div_wdata(i_div_wdata), .i_tune_we(i_tune_we), .i_tap_wdata(i_tap_wdata),
    .i_mod_wdata(i_mod_wdata), .i_fault_clr(i_fault_clr), .i_pin6_sel_we(i_pin6_sel_we),
    .i_pin6_sel_wdata(i_pin6_sel_wdata), .i_pin7_sel_we(i_pin7_sel_we),
    .i_pin7_sel_wdata(i_pin7_sel_wdata), .o_oscillator_range_select(o_oscillator_range_select),
    .o_aux_clock_divider(o_aux_clock_divider), .o_aux_div_applied(o_aux_div_applied),
    .o_oscillator_tap_select(o_oscillator_tap_select),
    .o_oscillator_modulation(o_oscillator_modulation),
    .o_oscillator_fault_flag(o_oscillator_fault_flag), .o_main_on_aux(o_main_on_aux),
    .o_wdog_on_aux(o_wdog_on_aux), .o_aux_en(o_aux_en),
    .o_port_two_bit_six_function_select(o_port_two_bit_six_function_select),
    .o_port_two_bit_seven_function_select(o_port_two_bit_seven_function_select),
    .o_pin7_gpio_en(o_pin7_gpio_en), .o_pin7_schmitt_en(o_pin7_schmitt_en));
  initial begin
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  // aux sources tick slowly so a divider change can be seen landing
  always @(negedge i_ref_clk) begin
    cycles++;
    if (cycles % 4 == 0) i_crystal_tick <= ~i_crystal_tick;
    if (cycles % 6 == 0) i_vlp_tick <= ~i_vlp_tick;
    if (cycles == 20000) begin
      err_count++;
      $display("MISMATCH t=%0t timeout", $time);
      results();
    end
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic chk_regs();
    `CHK(o_oscillator_range_select, m_range, "range")
    `CHK(o_aux_clock_divider, m_div, "divider readback")
    `CHK(o_oscillator_tap_select, m_tap, "tap")
    `CHK(o_oscillator_modulation, m_mod, "modulation")
  endtask
  task automatic do_reset();
    i_rstn = 1'b0;
    cyc(10);
    i_rstn = 1'b1;
    cyc(1);
    m_range = bcs_pkg::RANGE_RESET;
    m_div = bcs_pkg::DIV_RESET;
    m_tap = bcs_pkg::TAP_RESET;
    m_mod = bcs_pkg::MOD_RESET;
    chk_regs();
    `CHK(o_oscillator_fault_flag, 1'b0, "flag after reset")
    `CHK({o_pin7_gpio_en, o_pin7_schmitt_en}, 2'b10, "pin7 after reset")
    $display("test reset done");
  endtask
  task automatic wr_ctl(input logic [bcs_pkg::RANGE_W-1:0] r, input logic [bcs_pkg::DIV_W-1:0] d);
    i_ctl_we = 1'b1;
    i_range_wdata = r;
    i_div_wdata = d;
    @(negedge i_ref_clk);
    i_ctl_we = 1'b0;
    m_range = r;
    m_div = d;
    cyc(1);
    chk_regs();
  endtask
  task automatic wr_tune(input logic [bcs_pkg::TAP_W-1:0] t, input logic [bcs_pkg::MOD_W-1:0] m);
    // never retune with the range at its top value
    if (m_range == 4'hf) go_range(bcs_pkg::RANGE_RESET, m_div);
    i_tune_we = 1'b1;
    i_tap_wdata = t;
    i_mod_wdata = m;
    @(negedge i_ref_clk);
    i_tune_we = 1'b0;
    m_tap = t;
    m_mod = m;
    cyc(1);
    chk_regs();
  endtask
  // one range step per write, so 13 is passed on the way down
  task automatic go_range(input logic [bcs_pkg::RANGE_W-1:0] t,
    input logic [bcs_pkg::DIV_W-1:0] d);
    // from below 12 to above 13 the default range comes first
    if (m_range < 4'hc && t > 4'hd) go_range(bcs_pkg::RANGE_RESET, d);
    while (m_range != t) begin
      if (m_range < t) wr_ctl(m_range + 4'h1, d);
      else wr_ctl(m_range - 4'h1, d);
    end
    wr_ctl(t, d);
  endtask
  // one pulse per divided aux period; the crystal period here is 8 clocks
  task automatic chk_aux_en();
    int n;
    int k;
    n = 0;
    k = 0;
    while (o_aux_en !== 1'b1 && k < 600) begin
      @(negedge i_ref_clk);
      k++;
    end
    repeat (8 * (8 << m_div)) begin
      @(negedge i_ref_clk);
      if (o_aux_en === 1'b1) n++;
    end
    `CHK(n, 8, "aux enable pulses")
  endtask
  task automatic wr_pins(input logic p6, input logic p7);
    {i_pin6_sel_we, i_pin7_sel_we} = 2'b11;
    {i_pin6_sel_wdata, i_pin7_sel_wdata} = {p6, p7};
    @(negedge i_ref_clk);
    {i_pin6_sel_we, i_pin7_sel_we} = 2'b00;
    cyc(1);
    `CHK(o_port_two_bit_six_function_select, p6, "pin6 select")
    `CHK(o_port_two_bit_seven_function_select, p7, "pin7 select")
    `CHK({o_pin7_gpio_en, o_pin7_schmitt_en}, {~p7, p7}, "pin7 gpio and trigger")
  endtask
  task automatic fault_check(input logic vlp);
    int n;
    n = 0;
    i_aux_src_vlp = vlp;
    {i_main_from_aux, i_wdog_from_aux} = 2'b11;
    cyc(4);
    `CHK({o_main_on_aux, o_wdog_on_aux}, 2'b11, "aux selected")
    i_fault_detect = 1'b1;
    while (o_oscillator_fault_flag !== 1'b1 && n < 8) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (vlp) cyc(8);
    // the flag rises only for a crystal that feeds the aux clock
    `CHK(o_oscillator_fault_flag, ~vlp, "fault flag set")
    `CHK(n, vlp ? 8 : 3, "fault flag latency")
    `CHK({o_main_on_aux, o_wdog_on_aux}, {vlp, vlp}, "failsafe main")
    i_fault_clr = 1'b1;
    cyc(1);
    i_fault_clr = 1'b0;
    i_fault_detect = 1'b0;
    cyc(6);
    `CHK(o_oscillator_fault_flag, ~vlp, "flag sticky")
    i_fault_clr = 1'b1;
    cyc(1);
    i_fault_clr = 1'b0;
    cyc(2);
    `CHK({o_oscillator_fault_flag, o_main_on_aux, o_wdog_on_aux}, 3'b011, "flag cleared")
    $display("test fault done vlp=%0d", vlp);
  endtask
  task results();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    do_reset();
    // startup order: clear tuning, load control, load tuning
    wr_tune('0, '0);
    wr_ctl(4'ha, 2'h1);
    wr_tune(3'h5, 5'h0a);
    for (int i = 0; i < 12; i++) begin
      go_range(4'(rnd()), 2'(rnd()));
      wr_tune(3'(rnd()), 5'(rnd()));
    end
    cyc(40);
    `CHK(o_aux_div_applied, m_div, "divider applied")
    chk_aux_en();
    // a change during state three entry must not land until it ends
    i_sleep3 = 1'b1;
    wr_ctl(m_range, ~m_div);
    cyc(40);
    `CHK(o_aux_div_applied, ~m_div, "divider held in sleep")
    `CHK(o_aux_clock_divider, m_div, "readback in sleep")
    i_sleep3 = 1'b0;
    cyc(40);
    `CHK(o_aux_div_applied, m_div, "divider applied after sleep")
    // one aux period after a divider write, then state three may come and go
    wr_ctl(m_range, ~m_div);
    cyc(12);
    i_sleep3 = 1'b1;
    cyc(4);
    i_sleep3 = 1'b0;
    cyc(1);
    i_sleep3 = 1'b1;
    cyc(20);
    `CHK(o_aux_div_applied, m_div, "divider kept through state three")
    i_sleep3 = 1'b0;
    $display("test divider done");
    // the last pass leaves both pin selects set for the fault tests
    for (int i = 0; i < 4; i++) wr_pins(i[0], i[1]);
    $display("test pins done");
    fault_check(1'b0);
    fault_check(1'b1);
    do_reset();
    results();
  end
endmodule
